/* pkg/fault_response_map.vh */
// constants for the fault response and retry block
`ifndef FAULT_RESPONSE_MAP_VH
`define FAULT_RESPONSE_MAP_VH
// response byte fields
`define RESP_CODE_HI 7
`define RESP_CODE_LO 6
`define RESP_RETRY_HI 5
`define RESP_RETRY_LO 3
`define RESP_DELAY_HI 2
`define RESP_DELAY_LO 0
// response codes
`define CODE_IGNORE 2'h0
`define CODE_DELAYED 2'h1
`define CODE_RETRY 2'h2
`define CODE_LATCH 2'h3
// retry field values
`define RETRY_NONE 3'h0
`define RETRY_ALWAYS 3'h7
// delay time unit in ns and its cycle count at 250 MHz
`define CLK_PERIOD_NS 4
`define UNIT_TIME_NS 1000000
`define UNIT_CYCLES (`UNIT_TIME_NS / `CLK_PERIOD_NS)
`define RESET_RESP 8'h00
`endif

/* rtl/unit_tick.v */
// divider producing the fault delay time unit tick
`timescale 1ns/1ns
`default_nettype none
module unit_tick #(
  parameter integer CYCLES = 250000
) (
  input wire ref_clk,
  input wire arst_n,
  input wire clr,
  output wire tick
);
  // cycle counter, restarted by clr so each delay starts aligned
  reg [31:0] cnt_ff;
  assign tick = (cnt_ff == CYCLES - 1);
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 32'h0;
    end else if (clr || tick) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end
endmodule
`default_nettype wire

/* rtl/fault_response_retry.v */
// fault response policy: delay, disable and retry, or latch off
//
// What this block does
// - delayed code: run delay, then apply retry
// - code 10: disable at once, then retry
// - code 11: disable until a clearing event
// - status clear, clear-all or reset clears latch
// - off-then-on command or bias loss clears latch
// - retry 000: no restarts, stay disabled
// - restart spacing is delay count times unit
// - delay from bits 2:0 times fault unit
`timescale 1ns/1ns
`default_nettype none
`include "fault_response_map.vh"
module fault_response_retry #(
  parameter integer UNIT_CYCLES = `UNIT_CYCLES
) (
  input wire ref_clk,
  input wire arst_n,
  input wire [7:0] resp_byte,
  input wire fault_in,
  input wire status_bit_clear,
  input wire clear_faults_cmd,
  input wire reset_pin_n,
  input wire ctrl_pin,
  input wire operation_on,
  input wire bias_ok,
  output reg output_en_ff,
  output reg latched_ff,
  output reg [2:0] attempts_left_ff,
  output reg [1:0] state_out_ff
);
  // ---------------------------------------------------------------
  // synchronisers for pins from outside the clock domain
  // ---------------------------------------------------------------
  reg [4:0] s1_ff;
  reg [4:0] s2_ff;
  wire fault_s = s2_ff[0];
  wire rst_pin_s = s2_ff[1];
  wire ctrl_s = s2_ff[2];
  wire bias_s = s2_ff[3];
  wire op_s = s2_ff[4];
  // first stage read only by second stage
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 5'h0a;
      s2_ff <= 5'h0a;
    end else begin
      s1_ff <= {operation_on, bias_ok, ctrl_pin, reset_pin_n, fault_in};
      s2_ff <= s1_ff;
    end
  end
  // ---------------------------------------------------------------
  // on/off command tracking
  // ---------------------------------------------------------------
  // output wanted only when both pin and command ask for it
  wire run_req = ctrl_s & op_s;
  reg run_req_ff;
  reg off_seen_ff;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_req_ff <= 1'b0;
      off_seen_ff <= 1'b0;
    end else begin
      run_req_ff <= run_req;
      if (!run_req) begin
        off_seen_ff <= 1'b1;
      end else if (run_req_ff) begin
        off_seen_ff <= 1'b0;
      end
    end
  end
  // an off phase followed by on counts as a cycle of the output
  wire cycled = off_seen_ff & run_req & ~run_req_ff;
  wire clear_evt = status_bit_clear | clear_faults_cmd | ~rst_pin_s;
  wire bias_lost = ~bias_s;
  // ---------------------------------------------------------------
  // response byte fields
  // ---------------------------------------------------------------
  wire [1:0] code = resp_byte[`RESP_CODE_HI:`RESP_CODE_LO];
  wire [2:0] retry = resp_byte[`RESP_RETRY_HI:`RESP_RETRY_LO];
  wire [2:0] delay = resp_byte[`RESP_DELAY_HI:`RESP_DELAY_LO];
  // ---------------------------------------------------------------
  // delay timer in units of the fault time unit
  // ---------------------------------------------------------------
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_DELAY = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [1:0] ST_OFF = 2'h3;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [2:0] units_ff;
  reg [2:0] nxt_units;
  reg [2:0] nxt_attempts;
  reg nxt_latched;
  reg timer_clr;
  wire tick;
  // timer restarts with each new delay so spacing is exact in units
  unit_tick #(
    .CYCLES(UNIT_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clr(timer_clr),
    .tick(tick)
  );
  // delay elapsed once delay-count unit ticks have been seen
  wire expired = (units_ff == delay) & (delay == 3'h0 | tick) |
                 (units_ff + 3'h1 == delay) & tick;
  // ---------------------------------------------------------------
  // policy state machine
  // ---------------------------------------------------------------
  // retries left after a disable, or latch when none
  task go_retry;
    begin
      if (retry == `RETRY_NONE) begin
        nxt_state = ST_OFF;
        nxt_latched = 1'b1;
      end else if (retry != `RETRY_ALWAYS && attempts_left_ff == 3'h0) begin
        nxt_state = ST_OFF;
        nxt_latched = 1'b1;
      end else begin
        nxt_state = ST_WAIT;
        timer_clr = 1'b1;
        nxt_units = 3'h0;
        if (retry != `RETRY_ALWAYS) begin
          nxt_attempts = attempts_left_ff - 3'h1;
        end
      end
    end
  endtask
  always @* begin
    nxt_state = state_ff;
    nxt_units = units_ff;
    nxt_attempts = attempts_left_ff;
    nxt_latched = latched_ff;
    timer_clr = 1'b0;
    if (tick && units_ff != 3'h7) begin
      nxt_units = units_ff + 3'h1;
    end
    case (state_ff)
      ST_RUN: begin
        nxt_attempts = retry;
        if (fault_s && run_req) begin
          case (code)
            `CODE_DELAYED: begin
              nxt_state = ST_DELAY;
              timer_clr = 1'b1;
              nxt_units = 3'h0;
            end
            `CODE_RETRY: begin
              go_retry;
            end
            `CODE_LATCH: begin
              nxt_state = ST_OFF;
              nxt_latched = 1'b1;
            end
            default: begin
              nxt_state = ST_RUN;
            end
          endcase
        end
      end
      ST_DELAY: begin
        // output stays on through the delay
        if (!fault_s) begin
          nxt_state = ST_RUN;
        end else if (expired) begin
          go_retry;
        end
      end
      ST_WAIT: begin
        // output off; restart attempt when spacing has elapsed
        if (expired) begin
          nxt_state = ST_RUN;
        end
      end
      ST_OFF: begin
        nxt_state = ST_OFF;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
    // clearing events win over the fault for any off state
    // next state is tested, not the present one: a fault taken in the
    // same cycle as a clear would otherwise park the block off, unlatched
    if (clear_evt || cycled || bias_lost) begin
      nxt_latched = 1'b0;
      nxt_attempts = retry;
      if (nxt_state != ST_RUN && nxt_state != ST_DELAY) begin
        nxt_state = ST_RUN;
      end
    end
  end
  // state registers and registered outputs
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_RUN;
      units_ff <= 3'h0;
      attempts_left_ff <= 3'h0;
      latched_ff <= 1'b0;
      output_en_ff <= 1'b0;
      state_out_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
      units_ff <= nxt_units;
      attempts_left_ff <= nxt_attempts;
      latched_ff <= nxt_latched;
      state_out_ff <= nxt_state;
      // on only in run or delayed-action states and when commanded
      output_en_ff <= run_req & bias_s &
                      (nxt_state == ST_RUN || nxt_state == ST_DELAY);
    end
  end
endmodule
`default_nettype wire

/* verif/frr_asserts.sv */
// assertions for the fault response block
`timescale 1ns/1ns
`default_nettype none
module frr_asserts #(parameter integer UNIT_CYCLES = 4) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] resp_byte,
  input wire logic fault_in,
  input wire logic status_bit_clear,
  input wire logic clear_faults_cmd,
  input wire logic reset_pin_n,
  input wire logic ctrl_pin,
  input wire logic operation_on,
  input wire logic bias_ok,
  input wire logic output_en_ff,
  input wire logic latched_ff,
  input wire logic [2:0] attempts_left_ff,
  input wire logic [1:0] state_out_ff
);
  // ----------------------------------------
  // repeat counts assume a 4 cycle unit
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_latch_off: assert property (latched_ff |-> !output_en_ff && state_out_ff == 2'h3)
    else $error("latched yet on");
  a_latch_hold: assert property ((latched_ff && reset_pin_n && bias_ok && ctrl_pin
    && operation_on && !status_bit_clear && !clear_faults_cmd) [*6] |=> latched_ff)
    else $error("latch lost");
  a_clear_cmd: assert property ($rose(clear_faults_cmd) |-> ##[1:4] !latched_ff)
    else $error("clear ignored");
  a_bias_off: assert property (!bias_ok [*4] |-> !output_en_ff)
    else $error("on without bias");
  a_fast_off: assert property ($rose(fault_in) && resp_byte[7:6] == 2'h2 && output_en_ff
    |-> ##[1:4] !output_en_ff) else $error("slow disable");
  a_no_retry: assert property ($fell(output_en_ff) && resp_byte[7:3] == 5'h10 && bias_ok
    |-> ##[0:2] latched_ff) else $error("retried");
  a_delay_hold: assert property ($rose(fault_in) && resp_byte == 8'h42 && output_en_ff
    && bias_ok |-> output_en_ff [*8]) else $error("early stop");
  a_retry_gap: assert property ($fell(output_en_ff) && resp_byte == 8'hbb && bias_ok
    |-> !output_en_ff [*8]) else $error("early retry");
endmodule
bind fault_response_retry frr_asserts #(.UNIT_CYCLES(UNIT_CYCLES)) chk_u (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .resp_byte(resp_byte),
  .fault_in(fault_in),
  .status_bit_clear(status_bit_clear),
  .clear_faults_cmd(clear_faults_cmd),
  .reset_pin_n(reset_pin_n),
  .ctrl_pin(ctrl_pin),
  .operation_on(operation_on),
  .bias_ok(bias_ok),
  .output_en_ff(output_en_ff),
  .latched_ff(latched_ff),
  .attempts_left_ff(attempts_left_ff),
  .state_out_ff(state_out_ff)
);
`default_nettype wire

/* verif/host_pins_model.sv */
// model of the host side on and off commands
`timescale 1ns/1ns
`default_nettype none
module host_pins_model (
  input wire logic ref_clk,
  input wire logic cycle_req,
  output logic ctrl_pin,
  output logic operation_on
);
  logic [3:0] off_cnt_ff = 4'h0; // cycles left with both off
  // pin and command drop together, then both come back on
  always @(posedge ref_clk) begin
    if (cycle_req) off_cnt_ff <= 4'ha;
    else if (off_cnt_ff != 4'h0) off_cnt_ff <= off_cnt_ff - 4'h1;
  end
  assign ctrl_pin = (off_cnt_ff == 4'h0);
  assign operation_on = (off_cnt_ff == 4'h0);
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// bench for the fault response block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk, arst_n, fault_in, status_bit_clear, clear_faults_cmd, reset_pin_n;
  logic bias_ok, cycle_req, ctrl_pin, operation_on, output_en_ff, latched_ff;
  logic [7:0] resp_byte;
  logic [2:0] attempts_left_ff;
  logic [1:0] state_out_ff;
  int num_errors = 0;
  int samples_checked = 0;
  int ticks = 0;
  int n; // cycles spent in the last wait
  fault_response_retry #(.UNIT_CYCLES(4)) dut_u (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .resp_byte(resp_byte),
    .fault_in(fault_in),
    .status_bit_clear(status_bit_clear),
    .clear_faults_cmd(clear_faults_cmd),
    .reset_pin_n(reset_pin_n),
    .ctrl_pin(ctrl_pin),
    .operation_on(operation_on),
    .bias_ok(bias_ok),
    .output_en_ff(output_en_ff),
    .latched_ff(latched_ff),
    .attempts_left_ff(attempts_left_ff),
    .state_out_ff(state_out_ff)
  );
  host_pins_model pins_u (.ref_clk(ref_clk), .cycle_req(cycle_req), .ctrl_pin(ctrl_pin),
    .operation_on(operation_on));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %b got %b", what, exp, got);
    end
  endtask
  // bounded wait, n keeps the cycle count for spacing checks
  task automatic wait_en(input logic e);
    n = 0;
    while (output_en_ff !== e && n < 64) begin
      cyc(1);
      n++;
    end
    chk("output_en", e, output_en_ff);
  endtask
  task automatic fault(input logic [7:0] r, input int k);
    resp_byte <= r;
    fault_in <= 1'b1;
    cyc(k);
    fault_in <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, the run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    ticks <= ticks + 1;
    if (ticks == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    arst_n = 1'b0;
    {resp_byte, fault_in, status_bit_clear, clear_faults_cmd, cycle_req} = 12'h000;
    {reset_pin_n, bias_ok} = 2'h3;
    cyc(3);
    arst_n <= 1'b1;
    wait_en(1'b1);
    fault(8'h42, 4);
    cyc(20);
    chk("ride through", 1'b1, output_en_ff);
    fault(8'h42, 30);
    chk("delayed latch", 1'b1, latched_ff);
    chk("off state", 1'b1, state_out_ff == 2'h3);
    // each clearing event in turn, the first while still latched
    for (int c = 0; c < 5; c++) begin
      fault(8'hc0, 8);
      cyc(10);
      chk("latch held", 1'b1, latched_ff);
      case (c)
        0: status_bit_clear <= 1'b1;
        1: clear_faults_cmd <= 1'b1;
        2: reset_pin_n <= 1'b0;
        3: cycle_req <= 1'b1;
        default: bias_ok <= 1'b0;
      endcase
      cyc(6);
      {status_bit_clear, clear_faults_cmd, cycle_req} <= 3'h0;
      {reset_pin_n, bias_ok} <= 2'h3;
      wait_en(1'b1);
      chk("cleared", 1'b0, latched_ff);
    end
    fault(8'h80, 8);
    chk("no retry", 1'b1, latched_ff);
    clear_faults_cmd <= 1'b1;
    cyc(1);
    clear_faults_cmd <= 1'b0;
    wait_en(1'b1);
    fault(8'h89, 60);
    chk("retries spent", 1'b1, latched_ff);
    chk("none left", 1'b1, attempts_left_ff == 3'h0);
    clear_faults_cmd <= 1'b1;
    cyc(1);
    clear_faults_cmd <= 1'b0;
    wait_en(1'b1);
    resp_byte <= 8'hbb;
    fault_in <= 1'b1;
    wait_en(1'b0);
    wait_en(1'b1);
    chk("retry spacing", 1'b1, n >= 12 && n <= 13);
    fault_in <= 1'b0;
    wrap_up();
  end
endmodule
`default_nettype wire
